// File: src/bscc_pkg.sv
// Constants shared by the pad scan chain design
package bscc_pkg;

	localparam int CHAIN_LEN = 256;
	localparam int N_BIDIR   = 82;
	localparam int N_OUTP    = 2;
	localparam int N_CS      = 4;
	localparam int N_PADIN   = N_BIDIR + 2;

	// Chain positions, zero is next to the test data output
	localparam int IDX_WAIT     = 255;
	localparam int IDX_RESET    = 254;
	localparam int IDX_OUT_BASE = 250;
	localparam int IDX_CS_BASE  = 246;

	// Instruction register
	localparam int         IR_W       = 4;
	localparam logic [3:0] IR_EXTEST  = 4'h0;
	localparam logic [3:0] IR_SAMPLE  = 4'h1;
	localparam logic [3:0] IR_BYPASS  = 4'hf;
	localparam logic [3:0] IR_CAPTURE = 4'h1;

	// Reset values
	localparam logic [255:0] CHAIN_RESET  = 256'h0;
	localparam logic [N_CS-1:0] CS_RESET  = 4'hf;
	localparam logic [N_OUTP-1:0] OUT_RESET = 2'h0;
	localparam logic [N_BIDIR-1:0] BIDIR_RESET = 82'h0;

	typedef enum logic [3:0] {
		TAP_RESET,
		TAP_IDLE,
		TAP_SEL_DR,
		TAP_CAP_DR,
		TAP_SH_DR,
		TAP_EX1_DR,
		TAP_PA_DR,
		TAP_EX2_DR,
		TAP_UPD_DR,
		TAP_SEL_IR,
		TAP_CAP_IR,
		TAP_SH_IR,
		TAP_EX1_IR,
		TAP_PA_IR,
		TAP_EX2_IR,
		TAP_UPD_IR
	} bscc_tap_type;

endpackage : bscc_pkg

// File: src/bscc_sync.sv
// Two flip-flop synchroniser for signals from outside the clock domain
`timescale 1ns/1ps
module bscc_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta;
	logic [W-1:0] next_meta;
	logic [W-1:0] next_q;

	always_comb
	begin
		next_meta = d;
		next_q    = meta;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			meta <= '0;
			q    <= '0;
		end
		else
		begin
			meta <= next_meta;
			q    <= next_q;
		end
	end

endmodule : bscc_sync

// File: src/bscc_top.sv
// Boundary-scan cell chain between core and pads, with its test port
//
// Functional notes
// - Chain holds 256 cells for pins and controls
// - Input-only pin: one cell capturing pad level
// - Output-only pin: one data, one control cell; chip-select pins have a data cell only
// - Under scan control, data cell drives pad
// - Output-only control cell can float the pad
// - Bidirectional pin: data, input, control cells
// - Bidirectional input cell samples pad level
// - Bidirectional control cell selects pad direction
`timescale 1ns/1ps
module bscc_top
	import bscc_pkg::*;
(
	input  wire logic               CLK_SYS,
	input  wire logic               RST,
	input  wire logic               TCK,
	input  wire logic               TMS,
	input  wire logic               TDI,
	output logic                    TDO,
	output logic                    TDO_OE,
	output logic                    SCAN_ACTIVE,
	input  wire logic               WAIT_REQUEST_INPUT_N,
	input  wire logic               EXTERNAL_RESET_INPUT_N,
	output logic                    CORE_WAIT_N,
	output logic                    CORE_RESET_N,
	input  wire logic [N_OUTP-1:0]  CORE_OUT,
	output logic      [N_OUTP-1:0]  PAD_OUT,
	output logic      [N_OUTP-1:0]  PAD_OUT_OE,
	input  wire logic [N_CS-1:0]    CORE_CS,
	output logic      [N_CS-1:0]    PAD_CS,
	input  wire logic [N_BIDIR-1:0] CORE_BIDIR_OUT,
	input  wire logic [N_BIDIR-1:0] CORE_BIDIR_OE,
	output logic      [N_BIDIR-1:0] CORE_BIDIR_IN,
	input  wire logic [N_BIDIR-1:0] PAD_BIDIR_IN,
	output logic      [N_BIDIR-1:0] PAD_BIDIR_OUT,
	output logic      [N_BIDIR-1:0] PAD_BIDIR_OE
);

	logic [2:0]         link_s;
	logic [N_PADIN-1:0] pad_s;
	logic               tck_prev;
	logic               tck_rise;
	logic               tck_fall;
	logic               tms_s;
	logic               tdi_s;
	logic               wait_s;
	logic               reset_s;
	logic [N_BIDIR-1:0] bidir_s;

	bscc_sync #(.W(3)) u_link_sync (
		.clk (CLK_SYS),
		.rst (RST),
		.d   ({TDI, TMS, TCK}),
		.q   (link_s)
	);

	bscc_sync #(.W(N_PADIN)) u_pad_sync (
		.clk (CLK_SYS),
		.rst (RST),
		// Inverted so the cleared sync reads as released pins
		.d   ({~EXTERNAL_RESET_INPUT_N, ~WAIT_REQUEST_INPUT_N,
			PAD_BIDIR_IN}),
		.q   (pad_s)
	);

	assign tms_s    = link_s[1];
	assign tdi_s    = link_s[2];
	assign tck_rise = link_s[0] & ~tck_prev;
	assign tck_fall = ~link_s[0] & tck_prev;
	assign bidir_s  = pad_s[N_BIDIR-1:0];
	assign wait_s   = ~pad_s[N_BIDIR];
	assign reset_s  = ~pad_s[N_BIDIR+1];

	// Capture image of every cell
	logic [CHAIN_LEN-1:0] cap;

	assign cap[IDX_WAIT]  = wait_s;
	assign cap[IDX_RESET] = reset_s;

	genvar g;
	generate
		for (g = 0; g < N_OUTP; g++)
		begin : g_outp
			assign cap[IDX_OUT_BASE+2*g+1] = CORE_OUT[g];
			assign cap[IDX_OUT_BASE+2*g]   = 1'b1;
		end
		for (g = 0; g < N_CS; g++)
		begin : g_cs
			assign cap[IDX_CS_BASE+g] = CORE_CS[g];
		end
		for (g = 0; g < N_BIDIR; g++)
		begin : g_bidir
			assign cap[3*g+2] = CORE_BIDIR_OUT[g];
			assign cap[3*g+1] = bidir_s[g];
			assign cap[3*g]   = CORE_BIDIR_OE[g];
		end
	endgenerate

	// Test port state
	bscc_tap_type         state;
	bscc_tap_type         next_state;
	logic [IR_W-1:0]      ir_sh;
	logic [IR_W-1:0]      next_ir_sh;
	logic [IR_W-1:0]      ir;
	logic [IR_W-1:0]      next_ir;
	logic [CHAIN_LEN-1:0] pad_scan_chain;
	logic [CHAIN_LEN-1:0] next_pad_scan_chain;
	logic [CHAIN_LEN-1:0] upd;
	logic [CHAIN_LEN-1:0] next_upd;
	logic                 byp;
	logic                 next_byp;
	logic                 next_tdo;
	logic                 next_tdo_oe;
	logic                 sel_chain;

	assign sel_chain = (ir == IR_EXTEST) || (ir == IR_SAMPLE);

	always_comb
	begin
		next_state          = state;
		next_ir_sh          = ir_sh;
		next_ir             = ir;
		next_pad_scan_chain = pad_scan_chain;
		next_upd            = upd;
		next_byp            = byp;
		next_tdo            = TDO;
		next_tdo_oe         = TDO_OE;
		if (tck_rise)
		begin
			case (state)
				TAP_RESET:  next_state = tms_s ? TAP_RESET : TAP_IDLE;
				TAP_IDLE:   next_state = tms_s ? TAP_SEL_DR : TAP_IDLE;
				TAP_SEL_DR: next_state = tms_s ? TAP_SEL_IR : TAP_CAP_DR;
				TAP_CAP_DR: next_state = tms_s ? TAP_EX1_DR : TAP_SH_DR;
				TAP_SH_DR:  next_state = tms_s ? TAP_EX1_DR : TAP_SH_DR;
				TAP_EX1_DR: next_state = tms_s ? TAP_UPD_DR : TAP_PA_DR;
				TAP_PA_DR:  next_state = tms_s ? TAP_EX2_DR : TAP_PA_DR;
				TAP_EX2_DR: next_state = tms_s ? TAP_UPD_DR : TAP_SH_DR;
				TAP_UPD_DR: next_state = tms_s ? TAP_SEL_DR : TAP_IDLE;
				TAP_SEL_IR: next_state = tms_s ? TAP_RESET : TAP_CAP_IR;
				TAP_CAP_IR: next_state = tms_s ? TAP_EX1_IR : TAP_SH_IR;
				TAP_SH_IR:  next_state = tms_s ? TAP_EX1_IR : TAP_SH_IR;
				TAP_EX1_IR: next_state = tms_s ? TAP_UPD_IR : TAP_PA_IR;
				TAP_PA_IR:  next_state = tms_s ? TAP_EX2_IR : TAP_PA_IR;
				TAP_EX2_IR: next_state = tms_s ? TAP_UPD_IR : TAP_SH_IR;
				TAP_UPD_IR: next_state = tms_s ? TAP_SEL_DR : TAP_IDLE;
				default:    next_state = TAP_RESET;
			endcase
			case (state)
				TAP_CAP_DR:
				begin
					if (sel_chain)
						next_pad_scan_chain = cap;
					next_byp = 1'b0;
				end
				TAP_SH_DR:
				begin
					if (sel_chain)
						next_pad_scan_chain = {tdi_s,
							pad_scan_chain[CHAIN_LEN-1:1]};
					else
						next_byp = tdi_s;
				end
				TAP_CAP_IR: next_ir_sh = IR_CAPTURE;
				TAP_SH_IR:  next_ir_sh = {tdi_s, ir_sh[IR_W-1:1]};
				default:    next_ir_sh = ir_sh;
			endcase
		end
		if (tck_fall)
		begin
			// Output moves on the falling edge so the tester samples it stable
			case (state)
				TAP_SH_DR:
				begin
					next_tdo    = sel_chain ? pad_scan_chain[0] : byp;
					next_tdo_oe = 1'b1;
				end
				TAP_SH_IR:
				begin
					next_tdo    = ir_sh[0];
					next_tdo_oe = 1'b1;
				end
				TAP_UPD_DR:
				begin
					if (sel_chain)
						next_upd = pad_scan_chain;
					next_tdo_oe = 1'b0;
				end
				TAP_UPD_IR:
				begin
					next_ir     = ir_sh;
					next_tdo_oe = 1'b0;
				end
				TAP_RESET:
				begin
					next_ir     = IR_BYPASS;
					next_tdo_oe = 1'b0;
				end
				default: next_tdo_oe = 1'b0;
			endcase
		end
	end

	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
		begin
			tck_prev       <= 1'b0;
			state          <= TAP_RESET;
			ir_sh          <= IR_BYPASS;
			ir             <= IR_BYPASS;
			pad_scan_chain <= CHAIN_RESET;
			upd            <= CHAIN_RESET;
			byp            <= 1'b0;
			TDO            <= 1'b0;
			TDO_OE         <= 1'b0;
		end
		else
		begin
			tck_prev       <= link_s[0];
			state          <= next_state;
			ir_sh          <= next_ir_sh;
			ir             <= next_ir;
			pad_scan_chain <= next_pad_scan_chain;
			upd            <= next_upd;
			byp            <= next_byp;
			TDO            <= next_tdo;
			TDO_OE         <= next_tdo_oe;
		end
	end

	// Pad side: the chain takes over only under the external test
	logic                 ext;
	logic [N_OUTP-1:0]    next_pad_out;
	logic [N_OUTP-1:0]    next_pad_out_oe;
	logic [N_CS-1:0]      next_pad_cs;
	logic [N_BIDIR-1:0]   next_bidir_out;
	logic [N_BIDIR-1:0]   next_bidir_oe;

	assign ext = (ir == IR_EXTEST);

	always_comb
	begin
		for (int i = 0; i < N_OUTP; i++)
		begin
			next_pad_out[i]    = ext ? upd[IDX_OUT_BASE+2*i+1]
				: CORE_OUT[i];
			next_pad_out_oe[i] = ext ? upd[IDX_OUT_BASE+2*i]
				: 1'b1;
		end
		for (int i = 0; i < N_CS; i++)
			next_pad_cs[i] = ext ? upd[IDX_CS_BASE+i] : CORE_CS[i];
		for (int i = 0; i < N_BIDIR; i++)
		begin
			next_bidir_out[i] = ext ? upd[3*i+2]
				: CORE_BIDIR_OUT[i];
			next_bidir_oe[i]  = ext ? upd[3*i]
				: CORE_BIDIR_OE[i];
		end
	end

	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
		begin
			PAD_OUT       <= OUT_RESET;
			PAD_OUT_OE    <= OUT_RESET;
			PAD_CS        <= CS_RESET;
			PAD_BIDIR_OUT <= BIDIR_RESET;
			PAD_BIDIR_OE  <= BIDIR_RESET;
			CORE_BIDIR_IN <= BIDIR_RESET;
			CORE_WAIT_N   <= 1'b1;
			CORE_RESET_N  <= 1'b1;
			SCAN_ACTIVE   <= 1'b0;
		end
		else
		begin
			PAD_OUT       <= next_pad_out;
			PAD_OUT_OE    <= next_pad_out_oe;
			PAD_CS        <= next_pad_cs;
			PAD_BIDIR_OUT <= next_bidir_out;
			PAD_BIDIR_OE  <= next_bidir_oe;
			CORE_BIDIR_IN <= bidir_s;
			CORE_WAIT_N   <= wait_s;
			CORE_RESET_N  <= reset_s;
			SCAN_ACTIVE   <= ext;
		end
	end

endmodule : bscc_top

// File: test/bscc_chk_sva.sv
// Checker of the pad scan chain at the top-level ports
`timescale 1ns/1ps
module bscc_chk
	import bscc_pkg::*;
(
	input wire logic               CLK_SYS,
	input wire logic               RST,
	input wire logic               TCK,
	input wire logic               TDO,
	input wire logic               SCAN_ACTIVE,
	input wire logic               WAIT_REQUEST_INPUT_N,
	input wire logic               CORE_WAIT_N,
	input wire logic [N_OUTP-1:0]  CORE_OUT,
	input wire logic [N_OUTP-1:0]  PAD_OUT,
	input wire logic [N_OUTP-1:0]  PAD_OUT_OE,
	input wire logic [N_CS-1:0]    CORE_CS,
	input wire logic [N_CS-1:0]    PAD_CS,
	input wire logic [N_BIDIR-1:0] CORE_BIDIR_OUT,
	input wire logic [N_BIDIR-1:0] CORE_BIDIR_OE,
	input wire logic [N_BIDIR-1:0] CORE_BIDIR_IN,
	input wire logic [N_BIDIR-1:0] PAD_BIDIR_IN,
	input wire logic [N_BIDIR-1:0] PAD_BIDIR_OUT,
	input wire logic [N_BIDIR-1:0] PAD_BIDIR_OE
);
	logic [1:0] age;
	logic [1:0] next_age;
	logic       settled;
	// History before reset release must not be trusted by $past
	always_comb next_age = (age == 2'h3) ? age : age + 2'h1;
	always_ff @(posedge CLK_SYS or posedge RST)
		if (RST)
			age <= 2'h0;
		else
			age <= next_age;
	assign settled = (age == 2'h3);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	cs_follow_a: assert property (settled && !SCAN_ACTIVE &&
		!$past(SCAN_ACTIVE) && !$past(SCAN_ACTIVE, 2) |->
		PAD_CS == $past(CORE_CS)) else $error("cs pads ignore core");
	out_follow_a: assert property (settled && !SCAN_ACTIVE &&
		!$past(SCAN_ACTIVE) && !$past(SCAN_ACTIVE, 2) |->
		PAD_OUT == $past(CORE_OUT)) else $error("out pads ignore core");
	bidir_follow_a: assert property (settled && !SCAN_ACTIVE &&
		!$past(SCAN_ACTIVE) && !$past(SCAN_ACTIVE, 2) |->
		{PAD_BIDIR_OUT, PAD_BIDIR_OE} ==
		$past({CORE_BIDIR_OUT, CORE_BIDIR_OE}))
		else $error("bidir pads ignore core");
	// Long after a fall the update latch is quiet, so pads hold
	scan_hold_a: assert property (settled && SCAN_ACTIVE &&
		$past(SCAN_ACTIVE) && TCK && $past(TCK) && $past(TCK, 2) &&
		$past(TCK, 3) |-> $stable({PAD_OUT, PAD_OUT_OE, PAD_CS,
		PAD_BIDIR_OUT, PAD_BIDIR_OE})) else $error("forced pads moved");
	tdo_fall_a: assert property (settled && $changed(TDO) |->
		!$past(TCK) && !$past(TCK, 2)) else $error("data out off fall");
	scan_fall_a: assert property (settled &&
		$changed(SCAN_ACTIVE) |-> !$past(TCK) && !$past(TCK, 2))
		else $error("scan control off fall");
	wait_sync_a: assert property (settled |->
		CORE_WAIT_N == $past(WAIT_REQUEST_INPUT_N, 3))
		else $error("wait level late");
	bidir_sync_a: assert property (settled |->
		CORE_BIDIR_IN == $past(PAD_BIDIR_IN, 3))
		else $error("bidir level late");
	scan_on_c: cover property ($rose(SCAN_ACTIVE));
	float_c: cover property (SCAN_ACTIVE && PAD_OUT_OE == 2'h0);
	wait_low_c: cover property (!CORE_WAIT_N);
endmodule : bscc_chk
bind bscc_top bscc_chk u_chk (.*);

// File: test/bscc_tester.sv
// Behavioural boundary-scan tester on the test port
`timescale 1ns/1ps
module bscc_tester (
	output logic      TCK,
	output logic      TMS,
	output logic      TDI,
	input  wire logic TDO
);
	initial
	begin
		TCK = 1'h0;
		TMS = 1'h1;
		TDI = 1'h0;
	end
	// Clock stands low between frames
	task automatic tick(input logic m, input logic d, output logic o);
		TMS = m;
		TDI = d;
		#100;
		o = TDO;
		TCK = 1'h1;
		#200;
		TCK = 1'h0;
		#100;
	endtask : tick
	task automatic tap_reset();
		logic o;
		repeat (5) tick(1'h1, 1'($urandom), o);
		tick(1'h0, 1'h0, o);
	endtask : tap_reset
	task automatic scan(input int n, input logic [255:0] din,
		input logic ir, output logic [255:0] dout);
		logic o;
		dout = '0;
		tick(1'h1, 1'h0, o);
		if (ir)
			tick(1'h1, 1'h0, o);
		tick(1'h0, 1'h0, o);
		tick(1'h0, 1'h0, o);
		for (int i = 0; i < n; i++)
		begin
			tick(i == n - 1, din[i], o);
			dout[i] = o;
		end
		tick(1'h1, 1'h0, o);
		tick(1'h0, 1'h0, o);
	endtask : scan
endmodule : bscc_tester

// File: test/tb.sv
// Self-checking bench of the pad scan chain
`timescale 1ns/1ps
module tb;
	import bscc_pkg::*;
	logic CLK_SYS = 1'h0;
	logic RST = 1'h1;
	logic TCK, TMS, TDI, TDO, TDO_OE, SCAN_ACTIVE;
	logic tdo_line;
	logic WAIT_REQUEST_INPUT_N = 1'h1;
	logic EXTERNAL_RESET_INPUT_N = 1'h1;
	logic CORE_WAIT_N, CORE_RESET_N;
	logic [N_OUTP-1:0] CORE_OUT = '0, PAD_OUT, PAD_OUT_OE;
	logic [N_CS-1:0] CORE_CS = '1, PAD_CS;
	logic [N_BIDIR-1:0] CORE_BIDIR_OUT = '0, CORE_BIDIR_OE = '0, ext = '0;
	logic [N_BIDIR-1:0] CORE_BIDIR_IN, PAD_BIDIR_IN;
	logic [N_BIDIR-1:0] PAD_BIDIR_OUT, PAD_BIDIR_OE;
	logic [255:0] p, q;
	int n_mismatch = 0;
	int check_count = 0;
	assign PAD_BIDIR_IN = PAD_BIDIR_OE & PAD_BIDIR_OUT | ~PAD_BIDIR_OE & ext;
	always #25 CLK_SYS = ~CLK_SYS;
	bscc_top dut (.*);
	// A released data-out line shows the inverse to the tester
	assign tdo_line = TDO_OE ? TDO : ~TDO;
	bscc_tester tst (
		.TCK (TCK),
		.TMS (TMS),
		.TDI (TDI),
		.TDO (tdo_line)
	);
	function automatic logic [255:0] rnd256();
		logic [255:0] v;
		for (int j = 0; j < 8; j++)
			v[32*j+:32] = $urandom;
		return v;
	endfunction : rnd256
	function automatic logic [255:0] image();
		logic [255:0] v;
		v = '0;
		v[IDX_WAIT] = WAIT_REQUEST_INPUT_N;
		v[IDX_RESET] = EXTERNAL_RESET_INPUT_N;
		for (int i = 0; i < N_OUTP; i++)
			v[IDX_OUT_BASE+2*i+:2] = {CORE_OUT[i], 1'h1};
		for (int i = 0; i < N_CS; i++)
			v[IDX_CS_BASE+i] = CORE_CS[i];
		for (int k = 0; k < N_BIDIR; k++)
			v[3*k+:3] = {CORE_BIDIR_OUT[k], CORE_BIDIR_OE[k] ?
				CORE_BIDIR_OUT[k] : ext[k], CORE_BIDIR_OE[k]};
		return v;
	endfunction : image
	function automatic logic [255:0] pads(input logic [255:0] c);
		logic [N_OUTP-1:0]  o, e;
		logic [N_BIDIR-1:0] bo, be;
		for (int i = 0; i < N_OUTP; i++)
			{o[i], e[i]} = c[IDX_OUT_BASE+2*i+:2];
		for (int k = 0; k < N_BIDIR; k++)
			{bo[k], be[k]} = {c[3*k+2], c[3*k]};
		return 256'({o, e, c[IDX_CS_BASE+:N_CS], bo, be});
	endfunction : pads
	task automatic chk(input string what, input logic [255:0] exp,
		input logic [255:0] got);
		check_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic stir();
		@(negedge CLK_SYS);
		p = rnd256();
		{CORE_BIDIR_OUT, CORE_BIDIR_OE, ext} = p[245:0];
		{CORE_OUT, CORE_CS} = p[251:246];
		{WAIT_REQUEST_INPUT_N, EXTERNAL_RESET_INPUT_N} = p[253:252];
		repeat (5) @(negedge CLK_SYS);
	endtask : stir
	task automatic follow();
		chk("pads follow core", 256'({CORE_OUT,
			{N_OUTP{1'b1}}, CORE_CS, CORE_BIDIR_OUT, CORE_BIDIR_OE}),
			256'({PAD_OUT, PAD_OUT_OE, PAD_CS, PAD_BIDIR_OUT,
			PAD_BIDIR_OE}));
		chk("core sees pins", 256'({WAIT_REQUEST_INPUT_N,
			EXTERNAL_RESET_INPUT_N, PAD_BIDIR_IN}),
			256'({CORE_WAIT_N, CORE_RESET_N, CORE_BIDIR_IN}));
	endtask : follow
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : tally_and_finish
	initial
	begin
		p = 256'($urandom(32'h0a725c26));
		repeat (12) @(posedge CLK_SYS);
		@(negedge CLK_SYS);
		RST = 1'h0;
		stir();
		follow();
		tst.tap_reset();
		tst.scan(4, 256'(IR_SAMPLE), 1'h1, q);
		chk("instruction capture", 256'(IR_CAPTURE), 256'(q[3:0]));
		for (int i = 0; i < 3; i++)
		begin
			stir();
			tst.scan(256, rnd256(), 1'h0, q);
			chk("sampled chain", image(), q);
		end
		tst.scan(4, 256'(IR_EXTEST), 1'h1, q);
		// All-zero and all-one patterns float and drive every pad with a control cell; chip selects are driven low and high
		for (int i = 0; i < 3; i++)
		begin
			p = (i == 0) ? '0 : (i == 1) ? '1 : rnd256();
			q = p;
			tst.scan(256, q, 1'h0, p);
			stir();
			chk("forced pads", pads(q), 256'({PAD_OUT,
				PAD_OUT_OE,
				PAD_CS, PAD_BIDIR_OUT, PAD_BIDIR_OE}));
			chk("scan control", 256'h1, 256'(SCAN_ACTIVE));
		end
		tst.tap_reset();
		stir();
		follow();
		chk("scan released", 256'h0, 256'(SCAN_ACTIVE));
		// One-bit bypass: captured zero, then the data shifted in
		p = rnd256();
		tst.scan(8, p, 1'h0, q);
		chk("bypass path", 256'({p[6:0], 1'h0}), 256'(q[7:0]));
		chk("data out idle", 256'h0, 256'(TDO_OE));
		follow();
		tally_and_finish();
	end
	// Cuts a hung run short
	initial
	begin
		#4000000;
		n_mismatch++;
		tally_and_finish();
	end
endmodule : tb
